//--- bomr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bomr_assertions (
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     nrst_i,
  // Watched ports
  input wire bomr_pkg::bomr_cpu_req_t  cpu_req_i,
  input wire logic [7:0]               cpu_rdata_o,
  input wire bomr_pkg::bomr_link_bit_t link_i,
  input wire bomr_pkg::bomr_tx_evt_t   tx_evt_i,
  input wire logic                     rx_codeword_irq_o,
  input wire logic                     rx_message_active_o
);
  import bomr_pkg::*;
  // ---------
  // Config shadow
  // ---------
  logic [7:0] cfg_r;
  logic       rd_cw;
  logic       rd_st;
  assign rd_cw = cpu_req_i.rd && cpu_req_i.addr == BOMR_OFS_RX_CODEWORD;
  assign rd_st = cpu_req_i.rd && cpu_req_i.addr == BOMR_OFS_ACT_STATUS;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      cfg_r <= BOMR_CONFIG_RST;
    else if (cpu_req_i.wr && cpu_req_i.addr == BOMR_OFS_CONFIG)
      cfg_r <= cpu_req_i.wdata;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  stat_pad_a: assert property (rd_st |=> cpu_rdata_o[5:0] == 6'h00)
    else $error("status pad bits set");
  stat_rx_a: assert property (rd_st |=> cpu_rdata_o[6] == $past(rx_message_active_o))
    else $error("status rx bit wrong");
  read_clear_a: assert property ((rd_cw && !rx_codeword_irq_o) ##1 !rx_codeword_irq_o
    ##1 (rd_cw && !rx_codeword_irq_o) |=> cpu_rdata_o[7:6] == 2'b00) else $error("flags not cleared");
  irq_pulse_a: assert property (rx_codeword_irq_o |=> !rx_codeword_irq_o)
    else $error("irq wider than one cycle");
  irq_cause_a: assert property (rx_codeword_irq_o |-> $past(link_i.bit_stb))
    else $error("irq without link bit");
  tx_active_a: assert property (tx_evt_i.msg_start ##1 rd_st |=> cpu_rdata_o[7])
    else $error("tx activity missing");
  rx_pulse_a: assert property (cfg_r[7] && cfg_r[5:4] == 2'b00 && rx_message_active_o
    |=> !rx_message_active_o) else $error("rx activity not a pulse");
  rx_off_a: assert property ((!cfg_r[7]) [*2] |-> !rx_message_active_o)
    else $error("rx activity while disabled");
  load_c: cover property (rx_codeword_irq_o);
  lost_c: cover property (rd_cw ##1 cpu_rdata_o[7]);
  tx_c: cover property (rd_st ##1 cpu_rdata_o[7]);
endmodule : bomr_assertions
bind bomr_receiver bomr_assertions chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cpu_req_i(cpu_req_i),
  .cpu_rdata_o(cpu_rdata_o), .link_i(link_i), .tx_evt_i(tx_evt_i),
  .rx_codeword_irq_o(rx_codeword_irq_o), .rx_message_active_o(rx_message_active_o));
`default_nettype wire

//--- bomr_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module bomr_line_model (
  // Clock
  input  wire logic                     sys_clk_i,
  // Link bits
  output var  bomr_pkg::bomr_link_bit_t link_o
);
  import bomr_pkg::*;
  // ---------
  // Pattern sender
  // ---------
  initial link_o = '0;
  // Idle value is inverted so a stale bit is never mistaken for data
  task automatic put(input logic b, input int g);
    @(posedge sys_clk_i);
    #1;
    link_o = '{bit_val: b, bit_stb: 1'b1};
    @(posedge sys_clk_i);
    #1;
    link_o = '{bit_val: !b, bit_stb: 1'b0};
    repeat (g) @(posedge sys_clk_i);
  endtask : put
  task automatic send(input logic [5:0] cw, input int g);
    logic [15:0] p;
    p = {1'b0, cw, 1'b0, 8'hFF};
    for (int i = 0; i < 16; i++)
      put(p[i], g);
    repeat (3) @(posedge sys_clk_i);
  endtask : send
endmodule : bomr_line_model
`default_nettype wire

//--- bomr_pkg.sv
`default_nettype none
package bomr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] BOMR_OFS_CONFIG = 8'hA0;
  localparam logic [7:0] BOMR_OFS_RX_CODEWORD = 8'hA2;
  localparam logic [7:0] BOMR_OFS_ACT_STATUS = 8'hA3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BOMR_CFG_SEARCH_EN_BIT = 7;
  localparam int BOMR_CFG_INTEG_BIT = 6;
  localparam int BOMR_CFG_RXLEN_LSB = 4;
  localparam int BOMR_CFG_TXLEN_LSB = 2;
  localparam int BOMR_CW_VALID_BIT = 6;
  localparam int BOMR_CW_LOST_BIT = 7;
  localparam int BOMR_STAT_TX_ACT_BIT = 7;
  localparam int BOMR_STAT_RX_ACT_BIT = 6;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] BOMR_CONFIG_RST = 8'h00;
  localparam logic [5:0] BOMR_CW_RST = 6'h00;
  localparam logic [4:0] BOMR_PATTERN_BITS = 5'h10;
  localparam logic [3:0] BOMR_ONES_RUN = 4'h8;
  localparam logic [4:0] BOMR_COUNT_ONE = 5'h01;
  localparam logic [4:0] BOMR_COUNT_TEN = 5'h0A;
  localparam logic [4:0] BOMR_COUNT_25 = 5'h19;

  // ----------------------------------------
  // Length selections
  // ----------------------------------------
  typedef enum logic [1:0] {
    BOMR_LEN_ONE,
    BOMR_LEN_TEN,
    BOMR_LEN_25,
    BOMR_LEN_CHANGE
  } bomr_len_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } bomr_cpu_req_t;

  typedef struct packed {
    logic bit_val;
    logic bit_stb;
  } bomr_link_bit_t;

  typedef struct packed {
    logic msg_start;
    logic pattern_end;
  } bomr_tx_evt_t;

endpackage : bomr_pkg

`default_nettype wire

//--- bomr_receiver.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Qualified message loads 6-bit codeword, first bit lowest, and sets valid.
// - Processor read of codeword register clears valid flag in bit 6.
// - Load while valid still set raises overwrite flag in bit 7.
// - Transmit activity bit 7 stays high for whole configured message length.
// - Receive activity rises on eight ones, holds while framing zeros are right.
// - Pattern count one: receive activity is a pulse at pattern end.
// - Longer counts: activity high from first pattern until qualify; interrupt then.
// - When enabled, search bit stream for ones, zero, six codeword bits, zero.
// - 2-bit length picks one, ten, 25 patterns, or every change.
// - Gaps between patterns allowed unless a different valid codeword appears.
// - Integration: two identical back-to-back clean patterns count as one.
module bomr_receiver (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  // Processor port
  input  wire bomr_pkg::bomr_cpu_req_t cpu_req_i,
  output var  logic [7:0]              cpu_rdata_o,
  // Data link bit stream
  input  wire bomr_pkg::bomr_link_bit_t link_i,
  // Transmitter events
  input  wire bomr_pkg::bomr_tx_evt_t  tx_evt_i,
  // Status
  output var  logic                    rx_codeword_irq_o,
  output var  logic                    rx_message_active_o
);
  import bomr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]  config_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0]  since_match_r;
  logic        integ_have_r;
  logic [5:0]  integ_prev_r;
  logic [5:0]  cand_cw_r;
  logic [4:0]  cand_cnt_r;
  logic        cand_done_r;
  logic        loaded_any_r;
  logic [5:0]  rx_codeword_r;
  logic        rx_codeword_valid_r;
  logic        rx_codeword_overwritten_r;
  logic        ones_armed_r;
  logic [3:0]  ones_cnt_r;
  logic        rx_active_r;
  logic        tx_active_r;
  logic [4:0]  tx_cnt_r;

  logic        search_en;
  logic        integ_en;
  bomr_len_t   rx_len;
  bomr_len_t   tx_len;
  logic        stb;
  logic        match;
  logic [5:0]  match_cw;
  logic        eff_pat;
  logic        qualify;
  logic        rd_cw;
  logic        ones_now;
  logic        frame_fail;

  function automatic logic [4:0] len_target(input bomr_len_t len);
    if (len == BOMR_LEN_TEN) begin
      return BOMR_COUNT_TEN;
    end else if (len == BOMR_LEN_25) begin
      return BOMR_COUNT_25;
    end else begin
      return BOMR_COUNT_ONE;
    end
  endfunction : len_target

  assign search_en = config_r[BOMR_CFG_SEARCH_EN_BIT];
  assign integ_en  = config_r[BOMR_CFG_INTEG_BIT];
  assign rx_len    = bomr_len_t'(config_r[BOMR_CFG_RXLEN_LSB +: 2]);
  assign tx_len    = bomr_len_t'(config_r[BOMR_CFG_TXLEN_LSB +: 2]);
  assign stb       = link_i.bit_stb & search_en;
  assign rd_cw     = cpu_req_i.rd && (cpu_req_i.addr == BOMR_OFS_RX_CODEWORD);

  // ----------------------------------------
  // Pattern search
  // ----------------------------------------
  // Oldest bit sits at bit 0: ones in [7:0], zero, codeword, zero
  assign shift_nxt = {link_i.bit_val, shift_r[15:1]};
  assign match = stb && (shift_nxt[7:0] == 8'hFF) && !shift_nxt[8] && !shift_nxt[15];
  assign match_cw = shift_nxt[14:9];
  assign ones_now = stb && (shift_nxt[15:8] == 8'hFF);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_r <= 16'h0000;
    end else if (!search_en) begin
      shift_r <= 16'h0000;
    end else if (match) begin
      // Flush so one pattern is never seen twice
      shift_r <= 16'h0000;
    end else if (stb) begin
      shift_r <= shift_nxt;
    end
  end

  // ----------------------------------------
  // Integration
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_match_r <= 5'h00;
      integ_have_r  <= 1'b0;
      integ_prev_r  <= BOMR_CW_RST;
    end else if (!search_en) begin
      since_match_r <= 5'h00;
      integ_have_r  <= 1'b0;
    end else if (match) begin
      since_match_r <= 5'h00;
      integ_have_r  <= 1'b1;
      integ_prev_r  <= match_cw;
    end else if (stb) begin
      if (since_match_r == BOMR_PATTERN_BITS) begin
        // Slot after a pattern held no clean copy: gap or error
        integ_have_r <= 1'b0;
      end else begin
        since_match_r <= since_match_r + 5'h01;
      end
    end
  end

  // Back to back means exactly one pattern length since the last match
  assign eff_pat = match && (!integ_en || (integ_have_r && (since_match_r == BOMR_PATTERN_BITS - 5'h01)
                                           && (integ_prev_r == match_cw)));

  // ----------------------------------------
  // Pattern counting
  // ----------------------------------------
  always_comb begin
    qualify = 1'b0;
    if (eff_pat) begin
      if (rx_len == BOMR_LEN_CHANGE) begin
        qualify = !loaded_any_r || (match_cw != rx_codeword_r);
      end else if (match_cw != cand_cw_r || !cand_done_r) begin
        qualify = ((match_cw != cand_cw_r) ? BOMR_COUNT_ONE : cand_cnt_r + 5'h01) == len_target(rx_len);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cand_cw_r   <= BOMR_CW_RST;
      cand_cnt_r  <= 5'h00;
      cand_done_r <= 1'b0;
    end else if (!search_en) begin
      cand_cnt_r  <= 5'h00;
      cand_done_r <= 1'b0;
    end else if (eff_pat) begin
      if (match_cw != cand_cw_r) begin
        // A different valid codeword restarts the run
        cand_cw_r   <= match_cw;
        cand_cnt_r  <= BOMR_COUNT_ONE;
        cand_done_r <= qualify;
      end else if (!cand_done_r) begin
        cand_cnt_r  <= cand_cnt_r + 5'h01;
        cand_done_r <= qualify;
      end
    end
  end

  // ----------------------------------------
  // Codeword register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_codeword_r <= BOMR_CW_RST;
      loaded_any_r  <= 1'b0;
    end else if (qualify) begin
      rx_codeword_r <= match_cw;
      loaded_any_r  <= 1'b1;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_codeword_valid_r       <= 1'b0;
      rx_codeword_overwritten_r <= 1'b0;
    end else begin
      rx_codeword_valid_r <= qualify | (rx_codeword_valid_r & ~rd_cw);
      if (qualify) begin
        rx_codeword_overwritten_r <= rx_codeword_valid_r & ~rd_cw;
      end else if (rd_cw) begin
        rx_codeword_overwritten_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Receive activity
  // ----------------------------------------
  // Framing zeros checked eight bits after the ones run, at the last pattern bit
  assign frame_fail = ones_armed_r && stb && (ones_cnt_r == BOMR_ONES_RUN) && !match;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ones_armed_r <= 1'b0;
      ones_cnt_r   <= 4'h0;
    end else if (!search_en || match || frame_fail) begin
      ones_armed_r <= 1'b0;
      ones_cnt_r   <= 4'h0;
    end else if (ones_now) begin
      ones_armed_r <= 1'b1;
      ones_cnt_r   <= 4'h1;
    end else if (stb && ones_armed_r) begin
      ones_cnt_r <= ones_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_active_r <= 1'b0;
    end else if (!search_en) begin
      rx_active_r <= 1'b0;
    end else if (rx_len == BOMR_LEN_ONE) begin
      rx_active_r <= match;
    end else if (qualify || frame_fail) begin
      rx_active_r <= 1'b0;
    end else if (ones_now || match) begin
      rx_active_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_codeword_irq_o <= 1'b0;
    end else begin
      rx_codeword_irq_o <= qualify;
    end
  end

  assign rx_message_active_o = rx_active_r;

  // ----------------------------------------
  // Transmit activity
  // ----------------------------------------
  // Continuous length holds until software picks a finite length
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_active_r <= 1'b0;
      tx_cnt_r    <= 5'h00;
    end else if (tx_evt_i.msg_start) begin
      tx_active_r <= 1'b1;
      tx_cnt_r    <= 5'h00;
    end else if (tx_active_r && tx_evt_i.pattern_end && tx_len != BOMR_LEN_CHANGE) begin
      if (tx_cnt_r + 5'h01 >= len_target(tx_len)) begin
        tx_active_r <= 1'b0;
      end
      tx_cnt_r <= tx_cnt_r + 5'h01;
    end
  end

  // ----------------------------------------
  // Processor port
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      config_r <= BOMR_CONFIG_RST;
    end else if (cpu_req_i.wr && cpu_req_i.addr == BOMR_OFS_CONFIG) begin
      config_r <= cpu_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (cpu_req_i.rd) begin
      if (cpu_req_i.addr == BOMR_OFS_CONFIG) begin
        cpu_rdata_o <= config_r;
      end else if (cpu_req_i.addr == BOMR_OFS_RX_CODEWORD) begin
        cpu_rdata_o <= {rx_codeword_overwritten_r, rx_codeword_valid_r, rx_codeword_r};
      end else if (cpu_req_i.addr == BOMR_OFS_ACT_STATUS) begin
        cpu_rdata_o <= {tx_active_r, rx_active_r, 6'h00};
      end else begin
        cpu_rdata_o <= 8'h00;
      end
    end
  end

endmodule : bomr_receiver

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bomr_pkg::*;
  logic           sys_clk_i = 1'b0;
  logic           nrst_i = 1'b0;
  bomr_cpu_req_t  req = '0;
  bomr_link_bit_t lnk;
  bomr_tx_evt_t   tx = '0;
  logic [7:0]     rdata;
  logic           irq;
  logic           ract;
  logic           pend = 1'b0;
  logic [7:0]     expq[$];
  logic [5:0]     held = '0;
  logic [5:0]     cw;
  logic [5:0]     x;
  int bad_count = 0, n_tests = 0, cyc = 0, irq_n = 0, exp_irq = 0, n;
  always #2 sys_clk_i = ~sys_clk_i;
  bomr_receiver dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cpu_req_i(req), .cpu_rdata_o(rdata),
    .link_i(lnk), .tx_evt_i(tx), .rx_codeword_irq_o(irq), .rx_message_active_o(ract));
  bomr_line_model line_u (.sys_clk_i(sys_clk_i), .link_o(lnk));
  // ---------
  // Checking
  // ---------
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic end_of_test;
    $display("checks %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk_i) begin
    pend <= req.rd;
    cyc <= cyc + 1;
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
    if (cyc > 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  always @(negedge sys_clk_i)
    if (pend)
      cmp("read data", expq.pop_front(), rdata);
  // ---------
  // Bus and event drivers
  // ---------
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    req = '{addr: a, rd: !w, wr: w, wdata: d};
    @(posedge sys_clk_i);
    #1;
    req.rd = 1'b0;
    req.wr = 1'b0;
  endtask : acc
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd_chk
  task automatic send_run(input logic [5:0] c, input int k);
    for (int i = 0; i < k; i++)
      line_u.send(c, $urandom_range(2));
  endtask : send_run
  task automatic tx_ends(input int k);
    repeat (k) begin
      @(posedge sys_clk_i);
      #1;
      tx.pattern_end = 1'b1;
      @(posedge sys_clk_i);
      #1;
      tx.pattern_end = 1'b0;
    end
  endtask : tx_ends
  // ---------
  // Tests
  // ---------
  initial begin
    cw = 6'($urandom(88));
    repeat (12) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    rd_chk(BOMR_OFS_RX_CODEWORD, {2'b00, BOMR_CW_RST});
    rd_chk(8'h55, 8'h00);
    $display("done reset values");
    for (int m = 0; m < 4; m++) begin
      n = (m == 1) ? 10 : (m == 2) ? 25 : 1;
      acc(1'b1, BOMR_OFS_CONFIG, 8'h00);
      acc(1'b1, BOMR_OFS_CONFIG, {2'b10, 2'(m), 4'h0});
      cw = 6'($urandom);
      if (cw == held)
        cw = ~cw;
      if (n > 1) begin
        send_run(cw, n - 1);
        line_u.send(~cw, 1);
        send_run(cw, n - 1);
        rd_chk(BOMR_OFS_RX_CODEWORD, {2'b00, held});
        rd_chk(BOMR_OFS_ACT_STATUS, 8'h40);
        cmp("rx active pin", 8'h01, {7'h00, ract});
      end
      line_u.send(cw, 0);
      held = cw;
      exp_irq++;
      rd_chk(BOMR_OFS_RX_CODEWORD, {2'b01, cw});
      rd_chk(BOMR_OFS_RX_CODEWORD, {2'b00, cw});
      rd_chk(BOMR_OFS_ACT_STATUS, 8'h00);
      $display("done length mode %0d", m);
    end
    cw = ~held;
    x = cw ^ 6'h2A;
    line_u.send(cw, 0);
    line_u.send(x, 2);
    exp_irq += 2;
    rd_chk(BOMR_OFS_RX_CODEWORD, {2'b11, x});
    rd_chk(BOMR_OFS_RX_CODEWORD, {2'b00, x});
    $display("done overwrite");
    acc(1'b1, BOMR_OFS_CONFIG, 8'h00);
    acc(1'b1, BOMR_OFS_CONFIG, 8'hC0);
    cw = ~x;
    line_u.send(cw, 0);
    rd_chk(BOMR_OFS_RX_CODEWORD, {2'b00, x});
    line_u.send(cw, 1);
    exp_irq++;
    rd_chk(BOMR_OFS_RX_CODEWORD, {2'b01, cw});
    $display("done integration");
    for (int t = 0; t < 3; t++) begin
      n = (t == 1) ? 10 : (t == 2) ? 25 : 1;
      acc(1'b1, BOMR_OFS_CONFIG, {4'h0, 2'(t), 2'b00});
      @(posedge sys_clk_i);
      #1;
      tx.msg_start = 1'b1;
      @(posedge sys_clk_i);
      #1;
      tx.msg_start = 1'b0;
      expq.push_back(8'h80);
      req = '{addr: BOMR_OFS_ACT_STATUS, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      @(posedge sys_clk_i);
      #1;
      req.rd = 1'b0;
      tx_ends(n - 1);
      rd_chk(BOMR_OFS_ACT_STATUS, 8'h80);
      tx_ends(1);
      rd_chk(BOMR_OFS_ACT_STATUS, 8'h00);
      $display("done tx length %0d", t);
    end
    acc(1'b1, BOMR_OFS_CONFIG, 8'h0C);
    @(posedge sys_clk_i);
    #1;
    tx.msg_start = 1'b1;
    @(posedge sys_clk_i);
    #1;
    tx.msg_start = 1'b0;
    tx_ends(30);
    rd_chk(BOMR_OFS_ACT_STATUS, 8'h80);
    acc(1'b1, BOMR_OFS_CONFIG, 8'h00);
    tx_ends(1);
    rd_chk(BOMR_OFS_ACT_STATUS, 8'h00);
    $display("done tx continuous");
    repeat (3) @(posedge sys_clk_i);
    cmp("irq count", exp_irq[7:0], irq_n[7:0]);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
